// file: core/scd_pkg.sv
package scd_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CONFIG  = 8'h00;
   localparam logic [7:0] OFS_ISR     = 8'h04;
   localparam logic [7:0] OFS_MASK    = 8'h08;
   localparam logic [7:0] OFS_STATUS  = 8'h0C;

   // Configuration word field positions
   localparam int POS_PU   = 31;
   localparam int POS_SC   = 20;
   localparam int POS_SM   = 16;
   localparam int POS_VIS  = 12;
   localparam int POS_PSD  = 8;
   localparam int POS_BCR  = 7;
   localparam int POS_TOE  = 5;
   localparam int POS_SSEL = 4;
   localparam int POS_HS   = 3;
   localparam int POS_CM   = 0;

   // Writable bits of the configuration word; the rest read as zero
   localparam logic [31:0] CFG_WMASK   = 32'h8073_11BF;
   localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
   localparam int          IRQ_W       = 8;
   localparam logic [7:0]  ISR_RESET   = 8'h00;
   localparam logic [7:0]  MASK_RESET  = 8'h00;

   // Line code selector encodings
   localparam logic [2:0] SC_NRZ   = 3'h0;
   localparam logic [2:0] SC_BUS1  = 3'h1;
   localparam logic [2:0] SC_NRZI  = 3'h2;
   localparam logic [2:0] SC_BUS2  = 3'h3;
   localparam logic [2:0] SC_FM0   = 3'h4;
   localparam logic [2:0] SC_FM1   = 3'h5;
   localparam logic [2:0] SC_MANCH = 3'h6;

   // Protocol engine selector encodings
   localparam logic [1:0] SM_HDLC   = 2'h0;
   localparam logic [1:0] SM_BISYNC = 2'h2;
   localparam logic [1:0] SM_ASYNC  = 2'h3;

   // Clock modes with special meaning
   localparam logic [2:0] CM_HIGH_SPEED = 3'h4;
   localparam logic [2:0] CM_TIME_SLOT  = 3'h5;

   // Decoded line coding seen by the coder
   typedef enum logic [2:0] {
      SCD_LC_NRZ   = 3'b000,
      SCD_LC_NRZI  = 3'b001,
      SCD_LC_FM0   = 3'b010,
      SCD_LC_FM1   = 3'b011,
      SCD_LC_MANCH = 3'b100
   } scd_line_code_t;

   // Oversampled receive: clocks per bit and the three sample points
   localparam logic [3:0] OVS_LAST  = 4'hF;
   localparam logic [3:0] OVS_S0    = 4'h7;
   localparam logic [3:0] OVS_S1    = 4'h8;
   localparam logic [3:0] OVS_S2    = 4'h9;

   // Internal transmit clock derived from the system clock
   localparam int CLK_PERIOD_NS    = 20;
   localparam int TX_CLK_PERIOD_NS = 160;
   localparam int TX_HALF_CYC      = TX_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// file: core/scd_rx_sampler.sv
// Samples receive data on rising edges of the receive clock pin, once per
// clock or with 16x oversampling and a three-sample majority vote.
module scd_rx_sampler (
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Control
   input  wire logic enable,
   input  wire logic oversample,
   // Pins
   input  wire logic rx_clk_pin,
   input  wire logic rx_data_pin,
   // Recovered bits
   output logic      rx_bit,
   output logic      rx_bit_valid
);

   typedef struct packed {
      logic       clk_s1;
      logic       clk_s2;
      logic       clk_prev;
      logic       dat_s1;
      logic       dat_s2;
      logic       dat_prev;
      logic [3:0] cnt;
      logic [2:0] smp;
      logic       bit_q;
      logic       valid;
   } scd_smp_state_t;

   scd_smp_state_t s_q, s_d;

   // Majority of three samples
   function automatic logic scd_major(input logic [2:0] v);
      return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   // Edge finding runs on the second sync stage only
   always_comb begin
      s_d        = s_q;
      s_d.clk_s1 = rx_clk_pin;
      s_d.clk_s2 = s_q.clk_s1;
      s_d.dat_s1 = rx_data_pin;
      s_d.dat_s2 = s_q.dat_s1;
      s_d.valid  = 1'b0;
      if (s_q.clk_s2 && !s_q.clk_prev && enable) begin
         s_d.clk_prev = s_q.clk_s2;
         s_d.dat_prev = s_q.dat_s2;
         if (!oversample) begin
            s_d.bit_q = s_q.dat_s2;
            s_d.valid = 1'b1;
         end else begin
            // Data edge realigns the bit window
            if (s_q.dat_s2 != s_q.dat_prev) begin
               s_d.cnt = 4'h1;
            end else begin
               s_d.cnt = (s_q.cnt == scd_pkg::OVS_LAST) ? 4'h0
                                                        : s_q.cnt + 4'h1;
            end
            if (s_q.cnt == scd_pkg::OVS_S0) begin
               s_d.smp[0] = s_q.dat_s2;
            end
            if (s_q.cnt == scd_pkg::OVS_S1) begin
               s_d.smp[1] = s_q.dat_s2;
            end
            if (s_q.cnt == scd_pkg::OVS_S2) begin
               s_d.bit_q = scd_major({s_q.dat_s2, s_q.smp[1:0]});
               s_d.valid = 1'b1;
            end
         end
      end else begin
         s_d.clk_prev = s_q.clk_s2;
      end
   end

   // Single register stage for all sampler state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rx_bit       = s_q.bit_q;
   assign rx_bit_valid = s_q.valid;

endmodule

// file: core/scd_top.sv
// Overview of operation
// - Line code selector picks NRZ/NRZI/FM0/FM1/Manchester
// - Codes 001/011 select bus timing 1/2
// - Bus configuration always forces NRZ coding
// - Engine selector enables one engine, none while powered down
// - Mode-specific bits follow selected engine
// - Hidden: masked status absent from reads
// - Visible: masked status read and cleared
// - Masked sources never request a vector
// - Phase-shift disable acts with NRZ/NRZI only
// - Bit rate only async, modes 0,1,3b,7b
// - Rate 0: one sample per bit
// - Rate 1: 16x clocks, majority of three
// - Listed modes drive transmit clock out
// - Mode 5 drives time slot marker
// - Otherwise transmit clock pin is input
// - Option select picks a or b
// - High-speed bit switches paths, gating on
// - Clock mode selector decodes modes 0-7
// - Power-down stops engines, DMA still requests
module scd_top #(
   parameter int TX_HALF = scd_pkg::TX_HALF_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Events from the protocol engines
   input  wire logic [7:0]  irq_events,
   input  wire logic        tx_slot_active,
   input  wire logic        tx_fifo_room,
   // Serial pins
   input  wire logic        rx_clk_pin,
   input  wire logic        rx_data_pin,
   input  wire logic        tx_clock_pin_i,
   output logic             tx_clock_pin_o,
   output logic             tx_clock_pin_oe,
   // Decoded channel configuration
   output scd_pkg::scd_line_code_t line_coding,
   output logic [1:0]       bus_timing_mode,
   output logic             en_hdlc,
   output logic             en_bisync,
   output logic             en_async,
   output logic             dpll_phase_shift_off,
   output logic             dpll_window_extend,
   output logic [2:0]       clock_mode,
   output logic             clock_option_b,
   output logic             high_speed_active,
   output logic             clock_gating_en,
   output logic             dma_tx_request,
   output logic             irq_vector_req,
   output logic             tx_clock_in,
   // Recovered receive bits
   output logic             rx_bit,
   output logic             rx_bit_valid
);

   typedef struct packed {
      logic [31:0] cfg;
      logic [7:0]  interrupt_status_reg;
      logic [7:0]  mask;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      scd_pkg::scd_line_code_t lc;
      logic [1:0]  bus_mode;
      logic [2:0]  eng;
      logic        psd_off;
      logic [2:0]  cm;
      logic        opt_b;
      logic        hs;
      logic        dma_req;
      logic        vec;
      logic        oversample;
      logic [7:0]  div_cnt;
      logic        tx_int;
      logic        pin_o;
      logic        pin_oe;
      logic        txc_s1;
      logic        txc_s2;
   } scd_state_t;

   scd_state_t s_q, s_d;

   // Byte-lane merge of a bus write into a register
   function automatic logic [31:0] scd_merge(input logic [31:0] old,
                                             input logic [31:0] val,
                                             input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = val[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Configuration fields
   logic [2:0]  f_sc;
   logic [1:0]  f_sm;
   logic [2:0]  f_cm;
   logic        f_pu;
   logic        f_vis;
   logic        f_ssel;
   logic        f_toe;
   logic        sm_async;
   logic        sm_bisync;
   logic        nondpll;
   logic        tx_out_mode;
   logic [7:0]  isr_view;
   logic [31:0] cfg_view;
   logic        wr_fire;
   logic        rd_fire;

   assign f_sc   = s_q.cfg[scd_pkg::POS_SC +: 3];
   assign f_sm   = s_q.cfg[scd_pkg::POS_SM +: 2];
   assign f_cm   = s_q.cfg[scd_pkg::POS_CM +: 3];
   assign f_pu   = s_q.cfg[scd_pkg::POS_PU];
   assign f_vis  = s_q.cfg[scd_pkg::POS_VIS];
   assign f_ssel = s_q.cfg[scd_pkg::POS_SSEL];
   assign f_toe  = s_q.cfg[scd_pkg::POS_TOE];

   // Reserved engine code behaves as the reset code (HDLC)
   assign sm_async  = (f_sm == scd_pkg::SM_ASYNC);
   assign sm_bisync = (f_sm == scd_pkg::SM_BISYNC);

   // Non-DPLL clock modes: 0, 1, 3b, 7b; mode 4 excluded
   assign nondpll = (f_cm == 3'h0) || (f_cm == 3'h1)
                 || (f_cm == 3'h3 && f_ssel)
                 || (f_cm == 3'h7 && f_ssel);

   // Modes 0b, 2b, 3a, 3b, 6b, 7a, 7b may drive the clock out
   assign tx_out_mode = ((f_cm == 3'h0 || f_cm == 3'h2 || f_cm == 3'h6)
                         && f_ssel)
                     || (f_cm == 3'h3) || (f_cm == 3'h7);

   // Status read view: masked bits shown only when visible
   assign isr_view = f_vis ? s_q.interrupt_status_reg : (s_q.interrupt_status_reg & ~s_q.mask);

   // Rate bit has no meaning for the bisync engine
   assign cfg_view = sm_bisync ? (s_q.cfg & ~(32'h1 << scd_pkg::POS_BCR))
                               : s_q.cfg;

   assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
   assign rd_fire = s_axi_arvalid && !s_q.rvalid;

   // Bus slave, status, decode and pin control
   always_comb begin
      logic [7:0] clr;
      logic [7:0] rd_ofs;
      clr    = 8'h00;
      rd_ofs = s_axi_araddr & 8'hFC;
      s_d    = s_q;

      // Address and data channels taken independently
      if (s_axi_awvalid && !s_q.aw_got) begin
         s_d.aw_got  = 1'b1;
         s_d.aw_addr = s_axi_awaddr & 8'hFC;
      end
      if (s_axi_wvalid && !s_q.w_got) begin
         s_d.w_got  = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (wr_fire) begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = scd_pkg::RESP_OKAY;
         case (s_q.aw_addr)
            scd_pkg::OFS_CONFIG: begin
               s_d.cfg = scd_merge(s_q.cfg, s_q.w_data, s_q.w_strb)
                         & scd_pkg::CFG_WMASK;
            end
            scd_pkg::OFS_MASK: begin
               // Only lane 0 carries mask bits
               if (s_q.w_strb[0]) begin
                  s_d.mask = s_q.w_data[7:0];
               end
            end
            scd_pkg::OFS_ISR, scd_pkg::OFS_STATUS: begin
               s_d.bresp = scd_pkg::RESP_OKAY;
            end
            default: begin
               s_d.bresp = scd_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Read channel; status read clears what it returned
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (rd_fire) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = scd_pkg::RESP_OKAY;
         case (rd_ofs)
            scd_pkg::OFS_CONFIG: begin
               s_d.rdata = cfg_view;
            end
            scd_pkg::OFS_ISR: begin
               s_d.rdata = {24'h0, isr_view};
               clr       = isr_view;
            end
            scd_pkg::OFS_MASK: begin
               s_d.rdata = {24'h0, s_q.mask};
            end
            scd_pkg::OFS_STATUS: begin
               s_d.rdata = {24'h0, s_q.vec, s_q.pin_oe, s_q.hs,
                            s_q.oversample, s_q.eng, 1'b0};
            end
            default: begin
               s_d.rdata = 32'h0000_0000;
               s_d.rresp = scd_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Sticky status: a new event beats a clear in the same cycle
      s_d.interrupt_status_reg = (s_q.interrupt_status_reg & ~clr) | irq_events;
      s_d.vec = |(s_q.interrupt_status_reg & ~s_q.mask);

      // Line coding; bus modes and reserved code give NRZ
      s_d.bus_mode = 2'd0;
      case (f_sc)
         scd_pkg::SC_NRZ:   s_d.lc = scd_pkg::SCD_LC_NRZ;
         scd_pkg::SC_NRZI:  s_d.lc = scd_pkg::SCD_LC_NRZI;
         scd_pkg::SC_FM0:   s_d.lc = scd_pkg::SCD_LC_FM0;
         scd_pkg::SC_FM1:   s_d.lc = scd_pkg::SCD_LC_FM1;
         scd_pkg::SC_MANCH: s_d.lc = scd_pkg::SCD_LC_MANCH;
         scd_pkg::SC_BUS1: begin
            s_d.lc       = scd_pkg::SCD_LC_NRZ;
            s_d.bus_mode = 2'd1;
         end
         scd_pkg::SC_BUS2: begin
            s_d.lc       = scd_pkg::SCD_LC_NRZ;
            s_d.bus_mode = 2'd2;
         end
         default:           s_d.lc = scd_pkg::SCD_LC_NRZ;
      endcase

      // One engine at most, none while powered down
      s_d.eng = 3'b000;
      if (f_pu) begin
         s_d.eng = sm_async  ? 3'b100 :
                   sm_bisync ? 3'b010 : 3'b001;
      end
      s_d.dma_req = tx_fifo_room;

      // DPLL phase shift switch only for NRZ and NRZI
      s_d.psd_off = s_q.cfg[scd_pkg::POS_PSD]
                 && (f_sc == scd_pkg::SC_NRZ
                     || f_sc == scd_pkg::SC_NRZI);

      s_d.cm    = f_cm;
      s_d.opt_b = f_ssel && (f_cm != 3'h1) && (f_cm != 3'h4)
               && (f_cm != 3'h5);
      s_d.hs    = s_q.cfg[scd_pkg::POS_HS];

      // Oversampling only where the rate bit is meaningful
      s_d.oversample = s_q.cfg[scd_pkg::POS_BCR] && sm_async
                    && nondpll;

      // Internal transmit clock divider
      if (s_q.div_cnt >= 8'(TX_HALF - 1)) begin
         s_d.div_cnt = 8'h00;
         s_d.tx_int  = !s_q.tx_int;
      end else begin
         s_d.div_cnt = s_q.div_cnt + 8'h01;
      end

      // Transmit clock pin direction and source
      s_d.pin_oe = 1'b0;
      s_d.pin_o  = 1'b0;
      if (f_toe && tx_out_mode) begin
         s_d.pin_oe = 1'b1;
         s_d.pin_o  = s_q.tx_int;
      end else if (f_toe && f_cm == scd_pkg::CM_TIME_SLOT) begin
         s_d.pin_oe = 1'b1;
         s_d.pin_o  = tx_slot_active;
      end

      // Incoming transmit clock, two-stage synchroniser
      s_d.txc_s1 = tx_clock_pin_i;
      s_d.txc_s2 = s_q.txc_s1;
   end

   // Single register stage for the whole block
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q      <= '0;
         s_q.cfg  <= scd_pkg::CFG_RESET;
         s_q.interrupt_status_reg  <= scd_pkg::ISR_RESET;
         s_q.mask <= scd_pkg::MASK_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Receive sampler stopped while the channel is powered down
   scd_rx_sampler u_sampler (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .enable       (s_q.eng != 3'b000),
      .oversample   (s_q.oversample),
      .rx_clk_pin   (rx_clk_pin),
      .rx_data_pin  (rx_data_pin),
      .rx_bit       (rx_bit),
      .rx_bit_valid (rx_bit_valid)
   );

   // Outputs straight from the state register
   assign s_axi_awready        = !s_q.aw_got;
   assign s_axi_wready         = !s_q.w_got;
   assign s_axi_bvalid         = s_q.bvalid;
   assign s_axi_bresp          = s_q.bresp;
   assign s_axi_arready        = !s_q.rvalid;
   assign s_axi_rvalid         = s_q.rvalid;
   assign s_axi_rdata          = s_q.rdata;
   assign s_axi_rresp          = s_q.rresp;
   assign line_coding          = s_q.lc;
   assign bus_timing_mode      = s_q.bus_mode;
   assign en_hdlc              = s_q.eng[0];
   assign en_bisync            = s_q.eng[1];
   assign en_async             = s_q.eng[2];
   assign dpll_phase_shift_off = s_q.psd_off;
   assign dpll_window_extend   = s_q.psd_off;
   assign clock_mode           = s_q.cm;
   assign clock_option_b       = s_q.opt_b;
   assign high_speed_active    = s_q.hs;
   assign clock_gating_en      = s_q.hs;
   assign dma_tx_request       = s_q.dma_req;
   assign irq_vector_req       = s_q.vec;
   assign tx_clock_pin_o       = s_q.pin_o;
   assign tx_clock_pin_oe      = s_q.pin_oe;
   assign tx_clock_in          = s_q.txc_s2;

endmodule

// file: verification/scd_peer.sv
// Far-side line peer: drives receive clock and data, MSB first
module scd_peer (
   // Serial pins into the block
   output logic rx_clk_pin,
   output logic rx_data_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Clock idles low between frames
   initial begin
      rx_clk_pin = 1'h0;
      rx_data_pin = 1'h0;
   end
   // One byte, per_bit link clocks for every bit
   task automatic send(input logic [7:0] b, input int per_bit);
      #7;
      for (int i = 7; i >= 0; i--) begin
         rx_data_pin = b[i];
         repeat (per_bit) begin
            #80 rx_clk_pin = 1'h1;
            #80 rx_clk_pin = 1'h0;
         end
      end
      rx_data_pin = ~b[0]; // Stale bit must not look valid
   endtask
endmodule

// file: verification/scd_top_props.sv
// Port-level checks of the decoded channel configuration
module scd_top_props (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Channel side
   input wire logic tx_fifo_room,
   input wire logic dma_tx_request,
   input wire scd_pkg::scd_line_code_t line_coding,
   input wire logic [1:0] bus_timing_mode,
   input wire logic en_hdlc,
   input wire logic en_bisync,
   input wire logic en_async,
   input wire logic dpll_phase_shift_off,
   input wire logic high_speed_active,
   input wire logic clock_gating_en,
   input wire logic tx_clock_pin_oe,
   input wire logic [2:0] clock_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Handshake steps
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_bresp; s_wr_take |-> ##[1:2] s_axi_bvalid; endproperty
   a_bresp: assert property (p_bresp)
      else $error("write response late");
   property p_rresp; s_rd_take |-> ##[1:2] s_axi_rvalid; endproperty
   a_rresp: assert property (p_rresp)
      else $error("read response late");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_bhold: assert property (p_bhold)
      else $error("write response dropped");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold)
      else $error("read data not held");
   property p_onehot; $onehot0({en_hdlc, en_bisync, en_async}); endproperty
   a_onehot: assert property (p_onehot)
      else $error("several engines enabled");
   property p_busnrz; bus_timing_mode != 2'h0 |->
      line_coding == scd_pkg::SCD_LC_NRZ; endproperty
   a_busnrz: assert property (p_busnrz)
      else $error("bus mode without plain coding");
   property p_psd; dpll_phase_shift_off |-> line_coding inside
      {scd_pkg::SCD_LC_NRZ, scd_pkg::SCD_LC_NRZI}; endproperty
   a_psd: assert property (p_psd)
      else $error("phase shift off with edge coding");
   property p_gate; high_speed_active == clock_gating_en; endproperty
   a_gate: assert property (p_gate)
      else $error("gating does not follow high speed");
   property p_oe; clock_mode inside {3'h1, 3'h4} && $stable(clock_mode)
      |-> !tx_clock_pin_oe; endproperty
   a_oe: assert property (p_oe)
      else $error("clock pin driven in input-only mode");
   property p_dma; !$past(sys_rst) |->
      dma_tx_request == $past(tx_fifo_room); endproperty
   a_dma: assert property (p_dma)
      else $error("fifo request not passed on");
endmodule

bind scd_top scd_top_props i_scd_top_props (.*);

// file: verification/test_scd_top.sv
module test_scd_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 2;
   // Bench-driven inputs
   logic        clk = 1'h0, sys_rst = 1'h1;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, irq_events = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, tx_slot_active = 0;
   logic        tx_fifo_room = 0, peer_tx = 0, p;
   // Design outputs
   logic [1:0]  s_axi_bresp, s_axi_rresp, bus_timing_mode, rs;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, rx_clk_pin, rx_data_pin, tx_clock_pin_i;
   logic        tx_clock_pin_o, tx_clock_pin_oe, en_hdlc, en_bisync;
   logic        en_async, dpll_phase_shift_off, dpll_window_extend;
   logic        clock_option_b, high_speed_active, clock_gating_en;
   logic        dma_tx_request, irq_vector_req, tx_clock_in;
   logic        rx_bit, rx_bit_valid;
   logic [2:0]  clock_mode;
   logic [7:0]  rx_sh = '0;
   scd_pkg::scd_line_code_t line_coding;
   int          fails = 0, checks = 0, nrx = 0, n;
   logic [2:0]  lc_exp [8] = '{0, 0, 1, 0, 2, 3, 4, 0};
   logic [1:0]  bt_exp [8] = '{0, 1, 0, 2, 0, 0, 0, 0};
   logic [2:0]  en_exp [4] = '{4, 4, 2, 1};

   scd_top #(.TX_HALF(HALF)) i_scd_top (.*);
   scd_peer i_scd_peer (.rx_clk_pin, .rx_data_pin);

   // Clock pin level from both drivers
   assign tx_clock_pin_i = tx_clock_pin_oe ? tx_clock_pin_o : peer_tx;
   always #10 clk = ~clk;
   // Recovered bits, first one ends on top
   always @(posedge clk) begin
      if (rx_bit_valid === 1'h1) begin
         rx_sh <= {rx_sh[6:0], rx_bit};
         nrx <= nrx + 1;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Bounded wait for a handshake sampled high at an edge
   task automatic await(ref logic sig);
      int k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (sig !== 1'h1 && k < 200);
      if (sig !== 1'h1) begin
         fails++;
         tally_and_finish();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      await(s_axi_awready);
      s_axi_awvalid <= 1'h0;
      if (s_axi_wready !== 1'h1) await(s_axi_wready);
      s_axi_wvalid <= 1'h0;
      await(s_axi_bvalid);
      s_axi_bready <= 1'h0;
      rs = s_axi_bresp;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      await(s_axi_arready);
      s_axi_arvalid <= 1'h0;
      await(s_axi_rvalid);
      s_axi_rready <= 1'h0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
   endtask
   // Config write, then let the decode settle
   task automatic cfg(input logic [31:0] d);
      wr(scd_pkg::OFS_CONFIG, d);
      repeat (2) @(posedge clk);
   endtask
   task automatic pulse(input logic [7:0] e);
      irq_events <= e;
      @(posedge clk);
      irq_events <= 8'h00;
      repeat (3) @(posedge clk);
   endtask

   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'h0;
      @(posedge clk);
      rd_reg(scd_pkg::OFS_CONFIG);
      chk(rd, scd_pkg::CFG_RESET);
      rd_reg(8'h10);
      chk(rd, 32'h0000_0000);
      chk(rs, scd_pkg::RESP_SLVERR);
      wr(8'h10, 32'h0000_0000);
      chk(rs, scd_pkg::RESP_SLVERR);
      wr(scd_pkg::OFS_STATUS, 32'hFFFF_FFFF);
      chk(rs, scd_pkg::RESP_OKAY);
      $display("bus test done");
      for (int i = 0; i < 8; i++) begin
         cfg(32'h8000_0000 | (i << 20));
         chk(line_coding, lc_exp[i]);
         chk(bus_timing_mode, bt_exp[i]);
      end
      for (int i = 0; i < 4; i++) begin
         cfg(32'h8000_0080 | (i << 16));
         chk({en_hdlc, en_bisync, en_async}, en_exp[i]);
         rd_reg(scd_pkg::OFS_CONFIG);
         chk(rd, (i == 2) ? 32'h8002_0000 : 32'h8000_0080 | (i << 16));
      end
      cfg(32'h0003_0000);
      chk({en_hdlc, en_bisync, en_async}, 3'h0);
      tx_fifo_room <= 1'h1;
      repeat (2) @(posedge clk);
      chk(dma_tx_request, 1'h1);
      $display("coding and engine test done");
      for (int i = 0; i < 8; i++) begin
         cfg(32'h8000_0030 | i);
         chk(clock_mode, i[2:0]);
         chk(clock_option_b, !(i inside {1, 4, 5}));
         chk(tx_clock_pin_oe, !(i inside {1, 4}));
      end
      cfg(32'h8000_0030);
      n = 0;
      repeat (16) begin
         p = tx_clock_pin_o;
         @(posedge clk);
         n += (tx_clock_pin_o !== p);
      end
      chk(n, 16 / HALF);
      cfg(32'h8000_0025);
      tx_slot_active <= 1'h1;
      repeat (4) @(posedge clk);
      chk(tx_clock_pin_o, 1'h1);
      tx_slot_active <= 1'h0;
      repeat (4) @(posedge clk);
      chk(tx_clock_pin_o, 1'h0);
      cfg(32'h8000_0010);
      peer_tx <= 1'h1;
      repeat (5) @(posedge clk);
      chk({tx_clock_pin_oe, tx_clock_in}, 2'h1);
      $display("clock pin test done");
      cfg(32'h8000_010C);
      chk({dpll_phase_shift_off, dpll_window_extend}, 2'h3);
      chk({high_speed_active, clock_gating_en}, 2'h3);
      cfg(32'h8040_0104);
      chk({dpll_phase_shift_off, high_speed_active}, 2'h0);
      wr(scd_pkg::OFS_MASK, 32'h0000_000F);
      cfg(32'h8000_0000);
      pulse(8'h01);
      chk(irq_vector_req, 1'h0);
      rd_reg(scd_pkg::OFS_ISR);
      chk(rd, 32'h0000_0000);
      pulse(8'hF0);
      chk(irq_vector_req, 1'h1);
      rd_reg(scd_pkg::OFS_ISR);
      chk(rd, 32'h0000_00F0);
      repeat (2) @(posedge clk);
      chk(irq_vector_req, 1'h0);
      cfg(32'h8000_1000);
      rd_reg(scd_pkg::OFS_ISR);
      chk(rd, 32'h0000_0001);
      rd_reg(scd_pkg::OFS_ISR);
      chk(rd, 32'h0000_0000);
      $display("status test done");
      cfg(32'h8003_0000);
      n = nrx;
      i_scd_peer.send(8'hA5, 1);
      repeat (10) @(posedge clk);
      chk({nrx - n, rx_sh}, {32'd8, 8'hA5});
      cfg(32'h8003_0080);
      n = nrx;
      i_scd_peer.send(8'hA5, 16);
      repeat (10) @(posedge clk);
      chk({nrx - n, rx_sh}, {32'd8, 8'hA5});
      $display("receive test done");
      tally_and_finish();
   end
endmodule
